// ==== rtl/sfm_pkg.sv ====
package sfm_pkg;
    // ****************************************
    // Channel and frame sizing
    // ****************************************
    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 16;
    localparam int CLK_SYS_MHZ = 40;

    // ****************************************
    // Timing constants in their own units
    // ****************************************
    localparam int IN_DGL_US = 200;
    localparam int RST_DGL_US = 10;
    localparam int CLK_DGL_NS = 2000;
    localparam int WD_SHORT_MS = 32;
    localparam int WD_LONG_MS = 128;
    localparam int CLK_LOW_HZ = 100;

    // ****************************************
    // Derived cycle counts at the system clock rate
    // ****************************************
    localparam int IN_DGL_CYC = IN_DGL_US * CLK_SYS_MHZ;
    localparam int RST_DGL_CYC = RST_DGL_US * CLK_SYS_MHZ;
    localparam int CLK_DGL_CYC = CLK_DGL_NS * CLK_SYS_MHZ / 1000;
    localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_SYS_MHZ * 1000;
    localparam int WD_LONG_CYC = WD_LONG_MS * CLK_SYS_MHZ * 1000;
    localparam int CLK_LOW_CYC = CLK_SYS_MHZ * 1000000 / CLK_LOW_HZ;

    // ****************************************
    // Status bit positions in the frame reply word
    // ****************************************
    localparam int ST_FAIL_IN_BIT = 0;
    localparam int ST_SPI_FAIL_BIT = 1;
    localparam int ST_CLK_FAIL_BIT = 2;
    localparam int ST_FAIL_MODE_BIT = 3;

    // Supervisor operating mode
    typedef enum logic {SFM_NORMAL, SFM_FAIL} sfm_mode_t;

    // Fault flags grouped for reporting
    typedef struct packed {
        logic clkFail;
        logic spiFail;
        logic failIn;
    } sfm_status_t;
endpackage : sfm_pkg

// ==== rtl/sfm_supervisor.sv ====
`timescale 1ns/1ps
module sfm_supervisor
    import sfm_pkg::*;
#(
    parameter int NCH = NUM_CH,
    parameter int IN_DGL = IN_DGL_CYC,
    parameter int RST_DGL = RST_DGL_CYC,
    parameter int CLK_DGL = CLK_DGL_CYC,
    parameter int WD_SHORT = WD_SHORT_CYC,
    parameter int WD_LONG = WD_LONG_CYC,
    parameter int CLK_LOW = CLK_LOW_CYC
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pins from outside the clock domain
    input wire logic activeLowResetInput,
    input wire logic failModeInput,
    input wire logic [NCH-1:0] directChannelInputs,
    input wire logic pwmClockInput,
    input wire logic spiSupplyOk,
    input wire logic sleepMode,
    // Frame events from the SPI front end (same clock)
    input wire logic frameDone,
    input wire logic [7:0] frameEdgeCount,
    input wire logic watchdogToggleBit,
    input wire logic quickStatusRead,
    // Configuration from SPI registers (same clock)
    input wire logic watchdogPeriodSelect,
    input wire logic [NCH-1:0] pwmChannelOut,
    input wire logic [NCH-1:0] channelOnoffControl,
    input wire logic ch6Setting,
    // Outputs
    output logic [NCH-1:0] channelDrive,
    output logic externalSwitchControl,
    output logic deviceReset_n,
    output sfm_mode_t mode,
    output sfm_status_t status,
    output logic commFaultPulse
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NS = NCH + 4;
    logic [NS-1:0] syncA_q, syncB_q;
    // Two flops on every asynchronous pin except sleepMode, which is used without synchronising
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Supply pin idles high, so frames right after reset are not dropped
            syncA_q <= {1'b1, {(NS-1){1'b0}}};
            syncB_q <= {1'b1, {(NS-1){1'b0}}};
        end else begin
            syncA_q <= {spiSupplyOk, pwmClockInput, activeLowResetInput, failModeInput, directChannelInputs};
            syncB_q <= syncA_q;
        end
    end
    logic [NCH-1:0] dirSync;
    logic failSync, rstSync, clkSync, supplySync;
    assign dirSync = syncB_q[NCH-1:0];
    assign failSync = syncB_q[NCH];
    assign rstSync = syncB_q[NCH+1];
    assign clkSync = syncB_q[NCH+2];
    assign supplySync = syncB_q[NCH+3];

    // ****************************************
    // Symmetric deglitchers for fail input and direct inputs
    // ****************************************
    logic [NCH:0] dglOut_q;
    genvar gi;
    generate
        for (gi = 0; gi <= NCH; gi++) begin : g_dgl
            logic [23:0] cnt_q;
            logic raw;
            // Last lane carries the fail pin, the others the direct inputs
            if (gi == NCH) begin : g_fail
                assign raw = failSync;
            end else begin : g_dir
                assign raw = dirSync[gi];
            end
            // Output flips only once the pin has held its new level long enough
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q <= '0;
                    dglOut_q[gi] <= 1'b0;
                end else if (raw == dglOut_q[gi]) begin
                    cnt_q <= '0;
                end else if (cnt_q >= 24'(IN_DGL - 1)) begin
                    cnt_q <= '0;
                    dglOut_q[gi] <= raw;
                end else begin
                    cnt_q <= cnt_q + 24'h1;
                end
            end
        end
    endgenerate
    logic [NCH-1:0] filteredDirectInput;
    logic filteredFailRequest;
    assign filteredDirectInput = dglOut_q[NCH-1:0];
    assign filteredFailRequest = dglOut_q[NCH];

    // ****************************************
    // Reset pin: falling edge filtered, rising edge passes at once
    // ****************************************
    logic [15:0] rstCnt_q;
    logic rstFilt_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstCnt_q <= '0;
            rstFilt_q <= 1'b0;
        end else if (rstSync) begin
            rstCnt_q <= '0;
            rstFilt_q <= 1'b1;
        end else if (rstFilt_q) begin
            if (rstCnt_q >= 16'(RST_DGL - 1)) begin
                rstFilt_q <= 1'b0;
                rstCnt_q <= '0;
            end else begin
                rstCnt_q <= rstCnt_q + 16'h1;
            end
        end
    end
    assign deviceReset_n = rstFilt_q;

    // ****************************************
    // PWM clock deglitch and frequency watch
    // ****************************************
    logic [7:0] ckCnt_q;
    logic ckFilt_q, ckFiltPrev_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ckCnt_q <= '0;
            ckFilt_q <= 1'b0;
        end else if (clkSync == ckFilt_q) begin
            ckCnt_q <= '0;
        end else if (ckCnt_q >= 8'(CLK_DGL - 1)) begin
            ckCnt_q <= '0;
            ckFilt_q <= clkSync;
        end else begin
            ckCnt_q <= ckCnt_q + 8'h1;
        end
    end
    // Too-fast clock never passes the filter, so it looks like no edges: a clock failure
    logic [19:0] lowCnt_q;
    logic clkBad_q, clkLatched_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ckFiltPrev_q <= 1'b0;
            lowCnt_q <= '0;
            clkBad_q <= 1'b0;
        end else begin
            ckFiltPrev_q <= ckFilt_q;
            if (!rstFilt_q || (ckFilt_q && !ckFiltPrev_q)) begin
                lowCnt_q <= '0;
                clkBad_q <= 1'b0;
            end else if (lowCnt_q >= 20'(CLK_LOW - 1)) begin
                clkBad_q <= 1'b1;
            end else begin
                lowCnt_q <= lowCnt_q + 20'h1;
            end
        end
    end
    // Diagnosis stays until the failure is gone and quick status is then read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clkLatched_q <= 1'b0;
        end else if (clkBad_q) begin
            clkLatched_q <= 1'b1;
        end else if (quickStatusRead) begin
            clkLatched_q <= 1'b0;
        end
    end

    // ****************************************
    // SPI watchdog and frame checks
    // ****************************************
    logic wdPrev_q, wdSeen_q;
    logic [23:0] wdCnt_q;
    logic toggleErr, lengthErr, timeoutErr, frameGood, commFault;
    assign toggleErr = frameDone && wdSeen_q && (watchdogToggleBit == wdPrev_q);
    assign lengthErr = frameDone && (frameEdgeCount[3:0] != 4'h0);
    assign frameGood = frameDone && !toggleErr && !lengthErr && supplySync;
    assign timeoutErr = wdCnt_q >= (watchdogPeriodSelect ? 24'(WD_LONG - 1) : 24'(WD_SHORT - 1));
    assign commFault = toggleErr || lengthErr || timeoutErr;
    assign commFaultPulse = commFault;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdPrev_q <= 1'b0;
            wdSeen_q <= 1'b0;
            wdCnt_q <= '0;
        end else begin
            if (frameDone && supplySync) begin
                wdPrev_q <= watchdogToggleBit;
                wdSeen_q <= 1'b1;
            end
            // Without the output supply frames still get the length and toggle checks but do not restart the timer, so it runs out
            if (frameGood) begin
                wdCnt_q <= '0;
            end else if (!timeoutErr) begin
                wdCnt_q <= wdCnt_q + 24'h1;
            end
        end
    end

    // ****************************************
    // Mode control and fail flag
    // ****************************************
    logic spiFail_q;
    sfm_mode_t mode_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= SFM_NORMAL;
            spiFail_q <= 1'b0;
        end else begin
            if (filteredFailRequest || commFault || spiFail_q) begin
                mode_q <= SFM_FAIL;
            end else begin
                mode_q <= SFM_NORMAL;
            end
            // Set wins; leaving needs a good frame with no fail request
            if (commFault) begin
                spiFail_q <= 1'b1;
            end else if (frameGood && !filteredFailRequest) begin
                spiFail_q <= 1'b0;
            end
        end
    end
    assign mode = mode_q;
    assign status = '{clkFail: clkLatched_q, spiFail: spiFail_q, failIn: filteredFailRequest};

    // ****************************************
    // Output selection
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            channelDrive <= '0;
            externalSwitchControl <= 1'b0;
        end else begin
            if (mode_q == SFM_FAIL) begin
                channelDrive <= filteredDirectInput;
            end else if (clkBad_q) begin
                channelDrive <= channelOnoffControl;
            end else begin
                channelDrive <= pwmChannelOut;
            end
            externalSwitchControl <= (mode_q == SFM_NORMAL) && !sleepMode && ch6Setting;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_fault;
        commFault;
    endsequence
    sequence s_failHeld;
        mode_q == SFM_FAIL && spiFail_q ##1 mode_q == SFM_FAIL;
    endsequence
    AST_FAULT_TO_FAIL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_fault |=> s_failHeld) else $error("Fault did not enter fail mode");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        commFault |=> spiFail_q) else $error("Fail flag not set");
    AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(spiFail_q) |-> $past(frameGood) && !$past(commFault)) else $error("Fail flag dropped early");
    AST_FAIL_IN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        filteredFailRequest |=> mode_q == SFM_FAIL) else $error("Fail input ignored");
    AST_FAIL_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q == SFM_FAIL |=> channelDrive == $past(filteredDirectInput)) else $error("Fail drive wrong");
    AST_NORMAL_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q == SFM_NORMAL && !clkBad_q |=> channelDrive == $past(pwmChannelOut)) else $error("PWM drive wrong");
    AST_LOWCLK_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q == SFM_NORMAL && clkBad_q |=> channelDrive == $past(channelOnoffControl)) else $error("On/off drive wrong");
    AST_EXT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q == SFM_FAIL || sleepMode |=> !externalSwitchControl) else $error("External switch not off");
    AST_LENGTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frameDone && (frameEdgeCount % 8'(FRAME_BITS)) != 8'h00 |-> commFault) else $error("Length error missed");
    AST_EXT_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode_q == SFM_NORMAL && !sleepMode |=> externalSwitchControl == $past(ch6Setting))
        else $error("External switch wrong");
    AST_RST_FALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(deviceReset_n) |-> !$past(rstSync) && !$past(rstSync, 2))
        else $error("Reset fall not filtered");
    AST_CLK_DGL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(ckFilt_q) |-> $past(clkSync) == ckFilt_q && $past(clkSync, 2) == ckFilt_q)
        else $error("Clock glitch passed");
    AST_CLK_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkLatched_q && !quickStatusRead |=> clkLatched_q) else $error("Clock diagnosis lost");
    AST_RST_RISE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rstSync |=> deviceReset_n) else $error("Reset rise delayed");
endmodule : sfm_supervisor

// ==== tb/sfm_host_model.sv ====
`timescale 1ns/1ps
// ****
// Host link model
// ****
module sfm_host_model (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Requests from the bench
    input wire logic go,
    input wire logic keepBit,
    input wire logic [7:0] edges,
    // Frame events
    output logic frameDone,
    output logic [7:0] frameEdgeCount,
    output logic watchdogToggleBit
);
    logic lastBit_q;
    // One frame per request; fields churn while idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frameDone <= 1'b0;
            frameEdgeCount <= 8'h00;
            watchdogToggleBit <= 1'b0;
            lastBit_q <= 1'b0;
        end else if (go) begin
            frameDone <= 1'b1;
            frameEdgeCount <= edges;
            watchdogToggleBit <= keepBit ? lastBit_q : ~lastBit_q;
            lastBit_q <= keepBit ? lastBit_q : ~lastBit_q;
        end else begin
            frameDone <= 1'b0;
            frameEdgeCount <= ~frameEdgeCount;
            watchdogToggleBit <= ~watchdogToggleBit;
        end
    end
endmodule : sfm_host_model

// ==== tb/sfm_supervisor_test.sv ====
`timescale 1ns/1ps
// ****
// Supervisor bench
// ****
module sfm_supervisor_test
    import sfm_pkg::*;
;
    localparam int DGL = 8;
    localparam int CLOW = 100;
    logic clk_sys = 1'b0, rst_n = 1'b0, failIn = 1'b0, pwmClk = 1'b0, supOk = 1'b1;
    logic clkOn = 1'b1, ch6 = 1'b0, wdSel = 1'b1, qsRead = 1'b0, go = 1'b0, keepBit = 1'b0;
    logic rstPin = 1'b1, sleep = 1'b0;
    logic [NUM_CH-1:0] dirIn = '0, pwmOut = '0, onOff = '0, drive, x;
    logic [7:0] edges = 8'h10, edgeCnt;
    logic frameDone, wdBit, extSw, devRst_n, fault;
    sfm_mode_t mode;
    sfm_status_t status;
    logic [31:0] seed = 32'h85074cec, r;
    int nFail = 0, totalChecks = 0;

    sfm_supervisor #(.IN_DGL(DGL), .RST_DGL(4), .CLK_DGL(2), .WD_SHORT(200), .WD_LONG(800),
        .CLK_LOW(CLOW)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .activeLowResetInput(rstPin),
        .failModeInput(failIn), .directChannelInputs(dirIn), .pwmClockInput(pwmClk),
        .spiSupplyOk(supOk), .sleepMode(sleep), .frameDone(frameDone), .frameEdgeCount(edgeCnt),
        .watchdogToggleBit(wdBit), .quickStatusRead(qsRead), .watchdogPeriodSelect(wdSel),
        .pwmChannelOut(pwmOut), .channelOnoffControl(onOff), .ch6Setting(ch6),
        .channelDrive(drive), .externalSwitchControl(extSw), .deviceReset_n(devRst_n),
        .mode(mode), .status(status), .commFaultPulse(fault));
    sfm_host_model host (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .keepBit(keepBit),
        .edges(edges), .frameDone(frameDone), .frameEdgeCount(edgeCnt), .watchdogToggleBit(wdBit));

    // System clock and a free 200 ns PWM clock that can be stopped
    initial forever #12.5 clk_sys = ~clk_sys;
    initial begin
        #37;
        forever begin
            #100;
            pwmClk = clkOn ? ~pwmClk : 1'b0;
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Outputs are read at the edge, before that edge's own updates land, like a flop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic closeOut();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : closeOut

    task automatic chkBit(input string what, input logic e, input logic g);
        totalChecks++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : chkBit

    task automatic chkVec(input string what, input logic [NUM_CH-1:0] e, input logic [NUM_CH-1:0] g);
        totalChecks++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chkVec

    // Wait for mode (isClk 0) or the clock fault flag (isClk 1)
    task automatic waitSig(input logic isClk, input logic v, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            if ((isClk ? status.clkFail : logic'(mode)) === v) break;
            cyc(1);
        end
        if (k == lim) begin
            nFail++;
            $display("wrong value wait expected %b seen timeout", v);
            closeOut();
        end
    endtask : waitSig

    // Ask the host for one frame
    task automatic frame(input logic kb, input logic [7:0] n);
        @(posedge clk_sys);
        go <= 1'b1;
        keepBit <= kb;
        edges <= n;
        @(posedge clk_sys);
        go <= 1'b0;
        cyc(2);
    endtask : frame

    // Main sequence
    initial begin
        cyc(5);
        rst_n <= 1'b1;
        repeat (4) begin
            r = rnd();
            pwmOut <= r[3:0];
            ch6 <= r[4];
            onOff <= r[11:8];
            sleep <= r[6];
            dirIn <= r[15:12];
            frame(1'b0, r[5] ? 8'h20 : 8'h10);
            cyc(3);
            chkVec("drive", r[3:0], drive);
            chkBit("ext", r[4] && !r[6], extSw);
            chkBit("fault", 1'b0, fault);
        end
        $display("test normal done");
        for (int k = 0; k < 2; k++) begin
            frame(k == 0, k == 0 ? 8'h10 : 8'h0f);
            waitSig(1'b0, 1'b1, 3);
            chkBit("spiFail", 1'b1, status.spiFail);
            cyc(DGL + 6);
            chkVec("drive", dirIn, drive);
            chkBit("ext", 1'b0, extSw);
            chkBit("spiFail", 1'b1, status.spiFail);
            frame(1'b0, 8'h10);
            waitSig(1'b0, 1'b0, 4);
            chkBit("spiFail", 1'b0, status.spiFail);
        end
        $display("test frame faults done");
        for (int s = 0; s < 2; s++) begin
            wdSel <= s[0];
            frame(1'b0, 8'h10);
            if (s == 0) begin
                supOk <= 1'b0;
                cyc(90);
                frame(1'b0, 8'h10);
                cyc(80);
            end else begin
                cyc(770);
            end
            chkBit("mode", 1'b0, mode);
            waitSig(1'b0, 1'b1, 40);
            chkBit("fault", 1'b1, fault);
            supOk <= 1'b1;
            // A frame meeting the expired timer keeps the flag: the set wins
            repeat (2 - s) frame(1'b0, 8'h10);
            chkBit("spiFail", 1'b1, status.spiFail);
            frame(1'b0, 8'h10);
            waitSig(1'b0, 1'b0, 4);
        end
        $display("test watchdog done");
        failIn <= 1'b1;
        cyc(4);
        failIn <= 1'b0;
        cyc(20);
        chkBit("failIn", 1'b0, status.failIn);
        frame(1'b0, 8'h10);
        failIn <= 1'b1;
        waitSig(1'b0, 1'b1, DGL + 8);
        chkBit("failIn", 1'b1, status.failIn);
        x = dirIn;
        dirIn <= ~x;
        cyc(3);
        dirIn <= x;
        cyc(DGL + 6);
        chkVec("drive", x, drive);
        failIn <= 1'b0;
        frame(1'b0, 8'h10);
        waitSig(1'b0, 1'b0, DGL + 8);
        $display("test fail input done");
        clkOn <= 1'b0;
        waitSig(1'b1, 1'b1, CLOW + 40);
        cyc(2);
        chkVec("drive", onOff, drive);
        clkOn <= 1'b1;
        cyc(40);
        chkBit("clkFail", 1'b1, status.clkFail);
        qsRead <= 1'b1;
        cyc(1);
        qsRead <= 1'b0;
        cyc(4);
        chkBit("clkFail", 1'b0, status.clkFail);
        chkVec("drive", pwmOut, drive);
        $display("test clock fail done");
        // Short low pulse on the reset pin is swallowed, a long one passes
        rstPin <= 1'b0;
        cyc(2);
        rstPin <= 1'b1;
        cyc(6);
        chkBit("devRst", 1'b1, devRst_n);
        rstPin <= 1'b0;
        cyc(10);
        chkBit("devRst", 1'b0, devRst_n);
        // Rising edge shows after the two sync flops and one register only
        rstPin <= 1'b1;
        cyc(4);
        chkBit("devRst", 1'b1, devRst_n);
        $display("test reset pin done");
        closeOut();
    end
endmodule : sfm_supervisor_test
